// [common/icst_pkg.sv]
// Purpose: Shared constants, register map and carrier types for input conditioning.
// Assumes: 100 MHz sys_clk; registers sit at byte address four times their index.
// Notes:   Polarity digits are nibbles of the value; bit 0 of each nibble is the digit.
package icst_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_100US_NS = 100000;
    localparam int TICK_100US_CLKS = TICK_100US_NS / CLK_PERIOD_NS;
    localparam int CTRL_CYCLE_CLKS = 100;
    localparam int ALARM_UNIT_CYCLES = 2;

    // ==========================================================
    // Register indices
    localparam logic [15:0] IDX_INPUT_FILTER = 16'h3366;
    localparam logic [15:0] IDX_ALARM_FILTER = 16'h3367;
    localparam logic [15:0] IDX_POL_LOW = 16'h3368;
    localparam logic [15:0] IDX_POL_HIGH = 16'h3369;
    localparam logic [15:0] IDX_ENC_TOL = 16'h336b;
    localparam logic [15:0] IDX_ARRIVAL_LIMIT = 16'h336c;
    localparam logic [15:0] IDX_CTRL = 16'h3380;
    localparam logic [15:0] IDX_STATUS = 16'h3381;

    // ==========================================================
    // Reset values, limits and fields
    localparam logic [15:0] RST_INPUT_FILTER = 16'h0001;
    localparam logic [15:0] RST_ALARM_FILTER = 16'h0001;
    localparam logic [15:0] RST_POL_LOW = 16'h0000;
    localparam logic [15:0] RST_POL_HIGH = 16'h0000;
    localparam logic [15:0] RST_ENC_TOL = 16'h0003;
    localparam logic [15:0] RST_ARRIVAL_LIMIT = 16'h01f4;
    localparam logic [15:0] MAX_INPUT_FILTER = 16'h03e8;
    localparam logic [15:0] MAX_ALARM_FILTER = 16'h0003;
    localparam logic [15:0] MAX_ENC_TOL = 16'h2710;
    localparam logic [15:0] MAX_ARRIVAL_LIMIT = 16'hea60;
    localparam int CTRL_RESTART_BIT = 0;
    localparam int POL_DIGIT_W = 4;

    typedef struct packed {
        logic [15:0] input_filter_time;
        logic [15:0] alarm_output_filter_time;
        logic [15:0] input_polarity_select_low;
        logic [15:0] input_polarity_select_high;
        logic [15:0] encoder_error_tolerance;
        logic [15:0] position_arrival_time_limit;
    } icst_cfg_t;

    typedef struct packed {
        logic pos_arrived;
        logic enc_alarm;
        logic alarm_out;
        logic [4:0] di;
    } icst_status_t;

    // Byte address of a register index on the 32-bit bus.
    function automatic logic [15:0] icst_reg_addr(input logic [15:0] idx);
        return {idx[13:0], 2'b00};
    endfunction

    // Out-of-range writes saturate at the top of the legal range.
    function automatic logic [15:0] icst_clamp(input logic [15:0] v, input logic [15:0] mx);
        return (v > mx) ? mx : v;
    endfunction

endpackage

// [src/icst_filter.sv]
// Purpose: One debounce stage counting enable ticks while input and output differ.
// Assumes: raw is on sys_clk; tick is a one-cycle enable pulse.
// Notes:   A limit of zero passes a change on the next clock edge.
module icst_filter #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Control
    input wire logic tick,
    input wire logic rise_only,
    input wire logic [W-1:0] limit,
    // Data
    input wire logic raw,
    output logic filt
);

    logic [W-1:0] cnt_r;

    // ==========================================================
    // Filter
    // The count restarts whenever the input agrees again, so a glitch never accumulates.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
            filt <= 1'b0;
        end else if (raw == filt) begin
            cnt_r <= '0;
        end else if (rise_only && !raw) begin
            filt <= 1'b0;
            cnt_r <= '0;
        end else if (cnt_r >= limit) begin
            filt <= raw;
            cnt_r <= '0;
        end else if (tick) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    filt_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ($changed(filt) && !$past(rise_only)) |-> $past(cnt_r >= limit))
        else $error("filter output changed before its count expired");

endmodule // icst_filter

// [src/icst_top.sv]
// Purpose: Digital input conditioning, alarm output filter, encoder error tolerance
//          and position arrival timing, with an Avalon-MM register slave.
// Assumes: alarm_req, enc_comm_err and pos_in_window come from logic on sys_clk;
//          the five digital inputs are asynchronous pins.
// Notes:   Polarity settings are staged and only used after a restart command.
// ==========================================================
// Overview of operation
// R1: Each digital input is debounced for 0 to 1000 control cycles, default 1, live setting.
// R2: The alarm output is delayed on assertion by 0 to 3 units of two control cycles, default 1.
// R3: Digits 0 to 3 of the low polarity setting invert inputs a to d after a restart.
// R4: Digit 0 of the high polarity setting inverts input e after a restart; other digits stay.
// R5: Encoder communication errors lasting up to 0 to 10000 cycles, default 3, are ignored.
// R6: Position arrival needs the in-window state held for 0 to 60000 units of 0.1 ms, default 500.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
module icst_top #(
    parameter int CTRL_CLKS = icst_pkg::CTRL_CYCLE_CLKS,
    parameter int TICK_CLKS = icst_pkg::TICK_100US_CLKS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Digital input pins
    input wire logic digital_input_a,
    input wire logic digital_input_b,
    input wire logic digital_input_c,
    input wire logic digital_input_d,
    input wire logic digital_input_e,
    // Internal event sources
    input wire logic alarm_req,
    input wire logic enc_comm_err,
    input wire logic pos_in_window,
    // Conditioned outputs
    output icst_pkg::icst_status_t status
);

    icst_pkg::icst_cfg_t cfg_r;
    logic [4:0] pol_act_r;
    logic [4:0] din_meta_r;
    logic [4:0] din_sync_r;
    logic [15:0] ctrl_div_r;
    logic [15:0] tick_div_r;
    logic ctrl_tick_r;
    logic tick_100us_r;
    logic waitreq_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_nxt;
    logic req;
    logic wr_en;
    logic restart_wr;
    logic alarm_src;
    logic [4:0] pol_nxt;
    logic [4:0] di_cond;

    assign req = avs_read | avs_write;
    assign wr_en = avs_write && !waitreq_r;
    assign restart_wr = wr_en && avs_byteenable[0]
        && (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_CTRL))
        && avs_writedata[icst_pkg::CTRL_RESTART_BIT];
    assign avs_waitrequest = waitreq_r;
    assign avs_readdata = rdata_r;

    // Merge the enabled byte lanes into a 16-bit register, then saturate.
    function automatic logic [15:0] wr16(input logic [15:0] old, input logic [15:0] mx);
        logic [15:0] v;
        v = old;
        if (avs_byteenable[0]) begin
            v[7:0] = avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
            v[15:8] = avs_writedata[15:8];
        end
        return icst_pkg::icst_clamp(v, mx);
    endfunction

    // ==========================================================
    // Bus handshake
    // Every access takes one wait cycle; waitrequest is low for exactly one cycle.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            waitreq_r <= 1'b1;
        end else if (req && waitreq_r) begin
            waitreq_r <= 1'b0;
        end else begin
            waitreq_r <= 1'b1;
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_INPUT_FILTER)) begin
            rd_nxt[15:0] = cfg_r.input_filter_time;
        end else if (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_ALARM_FILTER)) begin
            rd_nxt[15:0] = cfg_r.alarm_output_filter_time;
        end else if (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_POL_LOW)) begin
            rd_nxt[15:0] = cfg_r.input_polarity_select_low;
        end else if (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_POL_HIGH)) begin
            rd_nxt[15:0] = cfg_r.input_polarity_select_high;
        end else if (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_ENC_TOL)) begin
            rd_nxt[15:0] = cfg_r.encoder_error_tolerance;
        end else if (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_ARRIVAL_LIMIT)) begin
            rd_nxt[15:0] = cfg_r.position_arrival_time_limit;
        end else if (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_STATUS)) begin
            rd_nxt[7:0] = status;
            rd_nxt[12:8] = pol_act_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && waitreq_r) begin
            rdata_r <= rd_nxt;
        end
    end

    // ==========================================================
    // Configuration registers
    // Filter and tolerance values feed the filters directly, so they act at once.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r.input_filter_time <= icst_pkg::RST_INPUT_FILTER;
            cfg_r.alarm_output_filter_time <= icst_pkg::RST_ALARM_FILTER;
            cfg_r.input_polarity_select_low <= icst_pkg::RST_POL_LOW;
            cfg_r.input_polarity_select_high <= icst_pkg::RST_POL_HIGH;
            cfg_r.encoder_error_tolerance <= icst_pkg::RST_ENC_TOL;
            cfg_r.position_arrival_time_limit <= icst_pkg::RST_ARRIVAL_LIMIT;
        end else if (wr_en) begin
            if (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_INPUT_FILTER)) begin
                cfg_r.input_filter_time <= wr16(cfg_r.input_filter_time,
                    icst_pkg::MAX_INPUT_FILTER); // [R1]
            end else if (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_ALARM_FILTER)) begin
                cfg_r.alarm_output_filter_time <= wr16(cfg_r.alarm_output_filter_time,
                    icst_pkg::MAX_ALARM_FILTER); // [R2]
            end else if (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_POL_LOW)) begin
                cfg_r.input_polarity_select_low <= wr16(cfg_r.input_polarity_select_low,
                    16'hffff);
            end else if (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_POL_HIGH)) begin
                cfg_r.input_polarity_select_high <= wr16(cfg_r.input_polarity_select_high,
                    16'hffff);
            end else if (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_ENC_TOL)) begin
                cfg_r.encoder_error_tolerance <= wr16(cfg_r.encoder_error_tolerance,
                    icst_pkg::MAX_ENC_TOL); // [R5]
            end else if (avs_address == icst_pkg::icst_reg_addr(icst_pkg::IDX_ARRIVAL_LIMIT)) begin
                cfg_r.position_arrival_time_limit <= wr16(cfg_r.position_arrival_time_limit,
                    icst_pkg::MAX_ARRIVAL_LIMIT); // [R6]
            end
        end
    end

    // ==========================================================
    // Polarity, latched only on restart
    // Reserved digits of the high setting are stored but never used.
    assign pol_nxt = {
        cfg_r.input_polarity_select_high[0], // [R4]
        cfg_r.input_polarity_select_low[3*icst_pkg::POL_DIGIT_W],
        cfg_r.input_polarity_select_low[2*icst_pkg::POL_DIGIT_W],
        cfg_r.input_polarity_select_low[icst_pkg::POL_DIGIT_W],
        cfg_r.input_polarity_select_low[0]
    };

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pol_act_r <= 5'h00;
        end else if (restart_wr) begin
            pol_act_r <= pol_nxt; // [R3] [R4]
        end
    end

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            din_meta_r <= 5'h00;
            din_sync_r <= 5'h00;
        end else begin
            din_meta_r <= {digital_input_e, digital_input_d, digital_input_c,
                digital_input_b, digital_input_a};
            din_sync_r <= din_meta_r;
        end
    end

    assign di_cond = din_sync_r ^ pol_act_r; // [R3] [R4]

    // ==========================================================
    // Time bases
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_div_r <= 16'h0000;
            ctrl_tick_r <= 1'b0;
        end else if (ctrl_div_r == 16'(CTRL_CLKS - 1)) begin
            ctrl_div_r <= 16'h0000;
            ctrl_tick_r <= 1'b1;
        end else begin
            ctrl_div_r <= ctrl_div_r + 16'h0001;
            ctrl_tick_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tick_div_r <= 16'h0000;
            tick_100us_r <= 1'b0;
        end else if (tick_div_r == 16'(TICK_CLKS - 1)) begin
            tick_div_r <= 16'h0000;
            tick_100us_r <= 1'b1;
        end else begin
            tick_div_r <= tick_div_r + 16'h0001;
            tick_100us_r <= 1'b0;
        end
    end

    // ==========================================================
    // Filters
    for (genvar i = 0; i < 5; i++) begin : g_din
        icst_filter #(.W(16)) u_din (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .tick(ctrl_tick_r),
            .rise_only(1'b0),
            .limit(cfg_r.input_filter_time), // [R1]
            .raw(di_cond[i]),
            .filt(status.di[i])
        );
    end

    // Error must outlast the tolerance, hence the limit of tolerance plus one.
    icst_filter #(.W(17)) u_enc (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .tick(ctrl_tick_r),
        .rise_only(1'b1),
        .limit({1'b0, cfg_r.encoder_error_tolerance} + 17'h00001), // [R5]
        .raw(enc_comm_err),
        .filt(status.enc_alarm)
    );

    assign alarm_src = alarm_req | status.enc_alarm;

    // Only assertion is delayed; clearing is immediate so a fault never lingers.
    icst_filter #(.W(16)) u_alarm (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .tick(ctrl_tick_r),
        .rise_only(1'b1),
        .limit(16'(cfg_r.alarm_output_filter_time * icst_pkg::ALARM_UNIT_CYCLES)), // [R2]
        .raw(alarm_src),
        .filt(status.alarm_out)
    );

    icst_filter #(.W(16)) u_pos (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .tick(tick_100us_r),
        .rise_only(1'b1),
        .limit(cfg_r.position_arrival_time_limit), // [R6]
        .raw(pos_in_window),
        .filt(status.pos_arrived)
    );

    // ==========================================================
    // Checks
    din_follow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $changed(status.di[0]) |-> status.di[0] == $past(di_cond[0])) // [R1]
        else $error("input a changed away from its conditioned level");

    din_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cfg_r.input_filter_time == 16'h0000 && di_cond[1] != status.di[1]
        && $stable(cfg_r.input_filter_time)) |=> status.di[1] == $past(di_cond[1])) // [R1]
        else $error("unfiltered input b did not pass on the next edge");

    alarm_delay_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ($rose(status.alarm_out) && cfg_r.alarm_output_filter_time != 16'h0000)
        |-> $past(alarm_src, 1) && $past(alarm_src, 2)) // [R2]
        else $error("alarm rose without a held source");

    alarm_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !alarm_src |=> !status.alarm_out) // [R2]
        else $error("alarm output outlived its source");

    pol_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $changed(pol_act_r[3:0]) |-> $past(restart_wr)
        && pol_act_r[0] == $past(cfg_r.input_polarity_select_low[0])) // [R3]
        else $error("low polarity changed without restart");

    pol_high_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        restart_wr |=> pol_act_r[4] == $past(cfg_r.input_polarity_select_high[0])) // [R4]
        else $error("input e polarity not taken at restart");

    enc_tol_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(status.enc_alarm) |-> $past(enc_comm_err, 1) && $past(enc_comm_err, 2)) // [R5]
        else $error("encoder alarm raised inside the tolerance");

    pos_arrive_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !pos_in_window |=> !status.pos_arrived) // [R6]
        else $error("arrival status held outside the window");

    bus_wait_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

endmodule // icst_top

// [tb/icst_sw_model.sv]
// Purpose: Switch and sensor model that drives the five digital input pins.
// Assumes: Level commands from the bench change right after a rising edge.
// Notes:   Chatter makes every contact bounce each cycle, as a worn switch does.
module icst_sw_model (
    // Clock
    input wire logic sys_clk,
    // Commands from the bench
    input wire logic [4:0] level,
    input wire logic chatter,
    // Pins
    output logic [4:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Contacts
    initial pins = 5'h00;
    // A bouncing contact never settles, so the debounce count must keep restarting.
    always @(posedge sys_clk) begin
        if (chatter) begin
            pins <= ~pins;
        end else begin
            pins <= level;
        end
    end
endmodule // icst_sw_model

// [tb/tb.sv]
// Purpose: Self-checking bench for input conditioning and status timing.
// Assumes: Short control cycle and tick parameters so that counts stay small.
// Notes:   Delays are checked against windows, since the first tick is partial.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CC = 4;
    localparam int TC = 8;
    logic sys_clk, rstn, avs_read, avs_write, avs_waitrequest;
    logic [15:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q, r, p;
    logic [3:0] avs_byteenable;
    logic alarm_req, enc_comm_err, pos_in_window, chatter;
    logic [4:0] level, pins, act;
    icst_pkg::icst_status_t st;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'haa98;
    int regs[int];
    int lim[int];
    int lat, n, v;
    logic bad;

    icst_top #(.CTRL_CLKS(CC), .TICK_CLKS(TC)) uut (.sys_clk(sys_clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .digital_input_a(pins[0]), .digital_input_b(pins[1]), .digital_input_c(pins[2]),
        .digital_input_d(pins[3]), .digital_input_e(pins[4]), .alarm_req(alarm_req),
        .enc_comm_err(enc_comm_err), .pos_in_window(pos_in_window), .status(st));
    icst_sw_model sw (.sys_clk(sys_clk), .level(level), .chatter(chatter), .pins(pins));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic timeout(input string what);
        error_cnt++;
        $display("Error %s expected answer seen timeout", what);
        finish_test();
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_rng(input string what, input int lo, input int hi, input int got);
        cmp_count++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // One Avalon access; the request stands until waitrequest is sampled low.
    task automatic bus(input logic [15:0] idx, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd);
        int k;
        k = 0;
        avs_address <= {idx[13:0], 2'b00};
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && k < 50) begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 50) timeout("bus");
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] val);
        bus(idx, 1'b1, {16'h0000, val}, q);
        if (regs.exists(int'(idx))) regs[int'(idx)] = (lim.exists(int'(idx)) &&
            int'(val) > lim[int'(idx)]) ? lim[int'(idx)] : int'(val);
    endtask

    task automatic rdchk(input string what, input logic [15:0] idx);
        bus(idx, 1'b0, 32'h0, q);
        check(what, regs.exists(int'(idx)) ? 32'(regs[int'(idx)]) : 32'h0, q);
    endtask

    task automatic wait_st(input int b, input logic val, input int mx, output int cnt);
        cnt = 0;
        while (st[b] !== val && cnt < mx) begin
            @(posedge sys_clk);
            cnt++;
        end
        if (cnt >= mx) timeout("status wait");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        avs_address = 16'h0000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h3;
        alarm_req = 1'b0;
        enc_comm_err = 1'b0;
        pos_in_window = 1'b0;
        chatter = 1'b0;
        level = 5'h00;
        act = 5'h00;
        regs['h3366] = 1;
        regs['h3367] = 1;
        regs['h3368] = 0;
        regs['h3369] = 0;
        regs['h336b] = 3;
        regs['h336c] = 500;
        lim['h3366] = 1000;
        lim['h3367] = 3;
        lim['h336b] = 10000;
        lim['h336c] = 60000;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        foreach (regs[i]) rdchk("reset value", 16'(i));
        rdchk("unmapped", 16'h3370);
        for (n = 0; n < 2; n++) begin
            foreach (regs[i]) begin
                wr(16'(i), n == 0 ? 16'hffff : rnd() % 16'hffff);
                rdchk("range write", 16'(i));
            end
        end
        $display("Test registers done");
        for (n = 0; n < 4; n++) begin
            v = rnd() % 5;
            r = rnd() % 5;
            wr(16'h3366, 16'(v));
            level <= level ^ (5'h01 << r);
            wait_st(r, ~level[r], 200, lat);
            check_rng("input filter delay", v > 0 ? (v - 1) * CC + 1 : 1, v * CC + 6, lat);
        end
        wr(16'h3366, 16'h0003);
        chatter <= 1'b1;
        bad = 1'b0;
        for (n = 0; n < 30; n++) begin
            @(posedge sys_clk);
            if (n == 20) chatter <= 1'b0;
            if (st.di !== level) bad = 1'b1;
        end
        check("chatter rejected", 32'h0, 32'(bad));
        $display("Test input filter done");
        wr(16'h3366, 16'h0000);
        for (n = 0; n < 3; n++) begin
            r = rnd();
            p = rnd();
            level <= p[4:0];
            wr(16'h3368, {3'h0, r[3], 3'h0, r[2], 3'h0, r[1], 3'h0, r[0]});
            wr(16'h3369, {15'h0000, r[4]});
            repeat (10) @(posedge sys_clk);
            check("polarity before restart", 32'(p[4:0] ^ act), 32'(st.di));
            wr(icst_pkg::IDX_CTRL, 16'h0001);
            act = r[4:0];
            repeat (10) @(posedge sys_clk);
            check("polarity after restart", 32'(p[4:0] ^ act), 32'(st.di));
            bus(icst_pkg::IDX_STATUS, 1'b0, 32'h0, q);
            check("active polarity", 32'(act), 32'(q[12:8]));
        end
        $display("Test polarity done");
        for (v = 0; v < 4; v++) begin
            wr(16'h3367, 16'(v));
            alarm_req <= 1'b1;
            wait_st(5, 1'b1, 200, lat);
            check_rng("alarm delay", v > 0 ? (2 * v - 1) * CC : 1, 2 * v * CC + 3, lat);
            alarm_req <= 1'b0;
            wait_st(5, 1'b0, 5, lat);
        end
        $display("Test alarm filter done");
        v = 2 + rnd() % 3;
        wr(16'h336b, 16'(v));
        enc_comm_err <= 1'b1;
        bad = 1'b0;
        for (n = 0; n < (v - 1) * CC + 10; n++) begin
            @(posedge sys_clk);
            if (n == (v - 1) * CC - 2) enc_comm_err <= 1'b0;
            if (st.enc_alarm !== 1'b0) bad = 1'b1;
        end
        check("short encoder error ignored", 32'h0, 32'(bad));
        enc_comm_err <= 1'b1;
        wait_st(6, 1'b1, 200, lat);
        check_rng("encoder alarm delay", v * CC, (v + 1) * CC + 3, lat);
        wait_st(5, 1'b1, 2 * 3 * CC + 20, lat);
        enc_comm_err <= 1'b0;
        wait_st(6, 1'b0, 5, lat);
        $display("Test encoder tolerance done");
        v = 2 + rnd() % 3;
        wr(16'h336c, 16'(v));
        pos_in_window <= 1'b1;
        wait_st(7, 1'b1, 200, lat);
        check_rng("arrival delay", (v - 1) * TC, v * TC + 3, lat);
        pos_in_window <= 1'b0;
        wait_st(7, 1'b0, 5, lat);
        $display("Test position arrival done");
        finish_test();
    end
endmodule // tb
